// ==== core/form_pkg.sv ====
// shared constants and carrier types for the file/offset register mapper
package form_pkg;
    // -----------------------------------------------------------------
    // address arithmetic
    // -----------------------------------------------------------------
    localparam int FILE_W = 8;
    localparam int OFS_W = 13;
    localparam int REG_W = 13;
    localparam int CNT_W = 13;
    localparam int DATA_W = 16;
    localparam int SLOT_W = 5;
    localparam logic [FILE_W-1:0] FILE_BASE = 8'h0A;
    localparam logic [FILE_W-1:0] FILE_LAST = 8'h36;
    localparam logic [FILE_W-1:0] FILE_BULK = 8'h3C;
    localparam logic [REG_W-1:0] FILE_STRIDE = 13'h0064;
    localparam logic [REG_W-1:0] REG_MIN = 13'h0001;
    localparam logic [REG_W-1:0] REG_MAX = 13'h1141;
    localparam logic [OFS_W-1:0] OFS_MAX = 13'h1141;
    localparam int BULK_SLOTS = 32;
    localparam logic [OFS_W-1:0] BULK_OFS_MAX = 13'h001F;
    localparam logic [CNT_W-1:0] BULK_SLOTS_C = 13'h0020;

    // -----------------------------------------------------------------
    // carriers
    // -----------------------------------------------------------------
    typedef struct packed {
        logic write;
        logic [FILE_W-1:0] file_num;
        logic [OFS_W-1:0] offset;
        logic [CNT_W-1:0] count;
    } form_req_t;

    typedef struct packed {
        logic write;
        logic [REG_W-1:0] index;
    } form_reg_t;
endpackage : form_pkg

// ==== core/form_mapper.sv ====
// file/offset to register index mapper for typed read and write service
`timescale 1ns/100ps
// Operation
// - register index is (file minus ten) times one hundred plus offset.
// - standard files are 10 to 54 and the index must be 1 to 4417.
// - a standard-file offset above 4417 is not accepted.
// - reads use the typed read service, writes the typed write service.
// - bulk assembly file reads follow the produced configuration array.
// - bulk assembly file writes follow the consumed configuration array.
// - bulk offsets run 0 to 31 and pick the starting array entry.
// - a bulk access from entry k covers at most 32 minus k elements.
// - a connection timeout or socket error raises the timeout event.
module form_mapper (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // request from the protocol front end
    input wire logic req_valid,
    input wire form_pkg::form_req_t req,
    output logic req_ready_q,
    // link fault pulses from the transport
    input wire logic link_timeout,
    input wire logic link_sock_err,
    output logic timeout_event_q,
    // configuration array load port
    input wire logic cfg_we,
    input wire logic cfg_consumed,
    input wire logic [form_pkg::SLOT_W-1:0] cfg_slot,
    input wire logic [form_pkg::REG_W-1:0] cfg_index,
    // register access stream, one element per cycle
    output logic acc_valid_q,
    output form_pkg::form_reg_t acc_q,
    output logic acc_last_q,
    // completion
    output logic done_q,
    output logic error_q
);
    // -----------------------------------------------------------------
    // configuration arrays
    // -----------------------------------------------------------------
    logic [form_pkg::REG_W-1:0] prod_q [form_pkg::BULK_SLOTS];
    logic [form_pkg::REG_W-1:0] cons_q [form_pkg::BULK_SLOTS];

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < form_pkg::BULK_SLOTS; i++) begin
                prod_q[i] <= '0;
                cons_q[i] <= '0;
            end
        end else if (cfg_we) begin
            if (cfg_consumed) begin
                cons_q[cfg_slot] <= cfg_index;
            end else begin
                prod_q[cfg_slot] <= cfg_index;
            end
        end
    end

    // -----------------------------------------------------------------
    // request checking
    // -----------------------------------------------------------------
    logic [form_pkg::REG_W+7:0] prod_wide;
    logic [form_pkg::REG_W+7:0] sum_wide;
    logic is_bulk;
    logic is_std;
    logic bulk_ok;
    logic std_ok;
    logic [form_pkg::CNT_W-1:0] bulk_room;

    // wide sum avoids wrap for large offsets before the range test
    assign prod_wide = 21'(req.file_num - form_pkg::FILE_BASE)
        * 21'(form_pkg::FILE_STRIDE);
    assign sum_wide = prod_wide + 21'(req.offset);
    assign is_bulk = req.file_num == form_pkg::FILE_BULK;
    assign is_std = req.file_num >= form_pkg::FILE_BASE
        && req.file_num <= form_pkg::FILE_LAST;
    assign bulk_room = form_pkg::BULK_SLOTS_C - req.offset;
    assign bulk_ok = req.offset <= form_pkg::BULK_OFS_MAX
        && req.count != '0 && req.count <= bulk_room;
    // the last visited index must also stay in range
    assign std_ok = req.offset <= form_pkg::OFS_MAX
        && req.count != '0
        && sum_wide >= 21'(form_pkg::REG_MIN)
        && sum_wide + 21'(req.count) - 21'd1
           <= 21'(form_pkg::REG_MAX);

    // -----------------------------------------------------------------
    // sequencer
    // -----------------------------------------------------------------
    typedef enum {ST_IDLE, ST_STD, ST_BULK, ST_END} form_state_t;
    form_state_t state_q;
    logic wr_q;
    logic [form_pkg::REG_W-1:0] idx_q;
    logic [form_pkg::SLOT_W-1:0] slot_q;
    logic [form_pkg::CNT_W-1:0] left_q;
    logic take;

    assign take = req_valid && req_ready_q;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            req_ready_q <= 1'b0;
            wr_q <= 1'b0;
            idx_q <= '0;
            slot_q <= '0;
            left_q <= '0;
            done_q <= 1'b0;
            error_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            error_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    req_ready_q <= 1'b1;
                    if (take) begin
                        req_ready_q <= 1'b0;
                        wr_q <= req.write;
                        left_q <= req.count;
                        slot_q <= req.offset[form_pkg::SLOT_W-1:0];
                        idx_q <= sum_wide[form_pkg::REG_W-1:0];
                        if (is_bulk && bulk_ok) begin
                            state_q <= ST_BULK;
                        end else if (is_std && std_ok) begin
                            state_q <= ST_STD;
                        end else begin
                            error_q <= 1'b1;
                            done_q <= 1'b1;
                            state_q <= ST_END;
                        end
                    end
                end
                ST_STD: begin
                    idx_q <= idx_q + 13'h0001;
                    left_q <= left_q - 13'h0001;
                    if (left_q == 13'h0001) begin
                        done_q <= 1'b1;
                        state_q <= ST_END;
                    end
                end
                ST_BULK: begin
                    slot_q <= slot_q + 5'h01;
                    left_q <= left_q - 13'h0001;
                    if (left_q == 13'h0001) begin
                        done_q <= 1'b1;
                        state_q <= ST_END;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // access stream
    // -----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            acc_valid_q <= 1'b0;
            acc_q <= '0;
            acc_last_q <= 1'b0;
        end else begin
            acc_valid_q <= state_q == ST_STD || state_q == ST_BULK;
            acc_last_q <= (state_q == ST_STD || state_q == ST_BULK)
                && left_q == 13'h0001;
            acc_q.write <= wr_q;
            if (state_q == ST_BULK) begin
                // read order from produced, write scatter from consumed
                acc_q.index <= wr_q ? cons_q[slot_q]
                    : prod_q[slot_q];
            end else begin
                acc_q.index <= idx_q;
            end
        end
    end

    // -----------------------------------------------------------------
    // timeout event
    // -----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            timeout_event_q <= 1'b0;
        end else begin
            timeout_event_q <= link_timeout || link_sock_err;
        end
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    sequence bad_take_s;
        take && !(is_bulk && bulk_ok) && !(is_std && std_ok);
    endsequence

    AST_TIMEOUT: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (link_timeout || link_sock_err) |=> timeout_event_q)
        else $error("timeout event missing");
    AST_REJECT: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        bad_take_s |=> error_q && done_q ##1 !acc_valid_q)
        else $error("bad request not rejected");
    AST_STD_STEP: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        acc_valid_q && !acc_last_q && $past(state_q) == ST_STD
        |=> acc_q.index == $past(acc_q.index) + 13'h0001)
        else $error("standard index not consecutive");
    AST_STD_START: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        take && is_std && std_ok
        |=> ##1 acc_valid_q && acc_q.index == $past(sum_wide[12:0], 2))
        else $error("start index wrong");
    AST_IDX_RANGE: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        acc_valid_q && $past(state_q) == ST_STD
        |-> acc_q.index >= form_pkg::REG_MIN
            && acc_q.index <= form_pkg::REG_MAX)
        else $error("index out of range");
    AST_BULK_RD: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        state_q == ST_BULK && !wr_q
        |=> acc_q.index == $past(prod_q[slot_q]))
        else $error("bulk read not from produced array");
    AST_BULK_WR: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        state_q == ST_BULK && wr_q
        |=> acc_q.index == $past(cons_q[slot_q]))
        else $error("bulk write not from consumed array");
    AST_BULK_LEN: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        take && is_bulk && req.offset == 13'h001F && req.count == 13'h0001
        |=> ##1 acc_valid_q && acc_last_q)
        else $error("bulk length wrong");
    AST_BULK_OFS: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        take && is_bulk && req.offset > form_pkg::BULK_OFS_MAX
        |=> error_q)
        else $error("bulk offset accepted");
    AST_DIR: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        take && !error_q ##1 state_q != ST_END
        |=> acc_q.write == $past(req.write, 2))
        else $error("direction lost");
endmodule : form_mapper

// ==== tb/form_requester.sv ====
// requester model: one file/offset request at a time
`timescale 1ns/100ps
module form_requester (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // request channel
    output form_pkg::form_req_t req,
    output logic req_valid,
    input wire logic req_ready_q
);
    initial begin
        req_valid = 1'b0;
        req = '0;
    end

    task automatic send(input form_pkg::form_req_t r, output logic ok);
        int n;
        ok = 1'b0;
        req_valid = 1'b1;
        req = r;
        for (n = 0; n < 64 && !ok; n++) begin
            @(negedge sys_clk);
            ok = (req_ready_q === 1'b1) && rstn;
            @(posedge sys_clk);
        end
        #1;
        req_valid = 1'b0;
        // released fields must not keep showing the old request
        req = ~r;
    endtask : send
endmodule : form_requester

// ==== tb/form_mapper_tb_top.sv ====
// testbench for the file/offset register mapper
`timescale 1ns/100ps
module form_mapper_tb_top;
    logic sys_clk, rstn, req_valid, req_ready_q;
    logic link_timeout, link_sock_err, timeout_event_q;
    logic cfg_we, cfg_consumed;
    logic [4:0] cfg_slot;
    logic [12:0] cfg_index;
    logic acc_valid_q, acc_last_q, done_q, error_q;
    form_pkg::form_req_t req;
    form_pkg::form_reg_t acc_q;
    form_pkg::form_reg_t got[$];
    form_pkg::form_reg_t exp_q[$];
    int err_total = 0;
    int num_checks = 0;

    form_mapper uut (.sys_clk(sys_clk), .rstn(rstn),
        .req_valid(req_valid), .req(req), .req_ready_q(req_ready_q),
        .link_timeout(link_timeout), .link_sock_err(link_sock_err),
        .timeout_event_q(timeout_event_q), .cfg_we(cfg_we),
        .cfg_consumed(cfg_consumed), .cfg_slot(cfg_slot),
        .cfg_index(cfg_index), .acc_valid_q(acc_valid_q), .acc_q(acc_q),
        .acc_last_q(acc_last_q), .done_q(done_q), .error_q(error_q));
    form_requester req_model (.sys_clk(sys_clk), .rstn(rstn), .req(req),
        .req_valid(req_valid), .req_ready_q(req_ready_q));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    always @(negedge sys_clk) if (acc_valid_q === 1'b1) got.push_back(acc_q);

    task check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task conclude;
        if (err_total == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude

    task automatic xfer(input logic w, input logic [7:0] f,
                        input logic [12:0] o, input logic [12:0] c,
                        input logic rej);
        logic ok;
        int n;
        got.delete();
        req_model.send({w, f, o, c}, ok);
        for (n = 0; n < 64 && done_q !== 1'b1; n++) @(negedge sys_clk);
        if (!ok || done_q !== 1'b1) begin
            err_total++;
            conclude();
        end
        check(error_q, rej);
        check(acc_last_q, !rej);
        @(negedge sys_clk);
        check(16'(got.size()), 16'(exp_q.size()));
        foreach (exp_q[i]) begin
            if (i < got.size()) check(got[i], exp_q[i]);
        end
        exp_q.delete();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : xfer

    task automatic t_std;
        int i;
        exp_q = '{'{1'b0, 13'd2050}, '{1'b0, 13'd2051}};
        xfer(1'b0, 8'd30, 13'd50, 13'd2, 1'b0);
        for (i = 0; i < 3; i++) exp_q.push_back('{1'b1, 13'(1798 + i)});
        xfer(1'b1, 8'd27, 13'd98, 13'd3, 1'b0);
    endtask : t_std

    task automatic t_table;
        int f[5] = '{12, 11, 54, 10, 20};
        int o[5] = '{62, 162, 17, 4417, 798};
        int r[5] = '{262, 262, 4417, 4417, 1798};
        foreach (f[i]) begin
            exp_q.push_back('{1'b0, 13'(r[i])});
            xfer(1'b0, 8'(f[i]), 13'(o[i]), 13'd1, 1'b0);
        end
    endtask : t_table

    task automatic t_reject;
        // file, offset, count: each one just outside a limit
        int f[9] = '{9, 55, 10, 10, 20, 54, 60, 60, 61};
        int o[9] = '{0, 0, 4418, 0, 5, 17, 32, 16, 0};
        int c[9] = '{1, 1, 1, 1, 0, 2, 1, 17, 1};
        foreach (f[i]) begin
            xfer(1'(i), 8'(f[i]), 13'(o[i]), 13'(c[i]), 1'b1);
        end
    endtask : t_reject

    task automatic t_bulk;
        int s;
        for (s = 0; s < 64; s++) begin
            cfg_we = 1'b1;
            cfg_consumed = s[5];
            cfg_slot = s[4:0];
            cfg_index = 13'(13'h0100 * (s[5] + 1) + s[4:0]);
            @(posedge sys_clk);
            #1;
        end
        cfg_we = 1'b0;
        for (s = 15; s < 31; s++) exp_q.push_back('{1'b0, 13'h0100 + 13'(s)});
        xfer(1'b0, 8'd60, 13'd15, 13'd16, 1'b0);
        exp_q.push_back('{1'b1, 13'h021F});
        xfer(1'b1, 8'd60, 13'd31, 13'd1, 1'b0);
        for (s = 0; s < 32; s++) exp_q.push_back('{1'b1, 13'h0200 + 13'(s)});
        xfer(1'b1, 8'd60, 13'd0, 13'd32, 1'b0);
    endtask : t_bulk

    task automatic t_fault;
        int k;
        for (k = 0; k < 2; k++) begin
            {link_sock_err, link_timeout} = 2'(k + 1);
            @(negedge sys_clk);
            #5;
            {link_sock_err, link_timeout} = 2'b00;
            @(negedge sys_clk);
            check(timeout_event_q, 1'b1);
            @(negedge sys_clk);
            check(timeout_event_q, 1'b0);
            @(posedge sys_clk);
            #1;
        end
    endtask : t_fault

    initial begin
        rstn = 1'b0;
        {link_timeout, link_sock_err, cfg_we, cfg_consumed} = 4'h0;
        cfg_slot = 5'h00;
        cfg_index = 13'h0000;
        repeat (16) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        t_std();
        t_table();
        t_reject();
        t_bulk();
        t_fault();
        conclude();
    end
endmodule : form_mapper_tb_top
